// ==== hdl/lrc_pkg.sv ====
package lrc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;

   // Global registers
   localparam logic [10:0] GLB_RESET_OFF = 11'h040;
   localparam logic [10:0] GLB_GPIO_OFF = 11'h100;
   localparam logic [10:0] GLB_BUSY_LO_OFF = 11'h200;
   localparam logic [10:0] GLB_BUSY_HI_OFF = 11'h201;

   // Channel pages: addr[10:9] = 2'b10, channel in addr[8:5], offset below
   localparam logic [1:0] CHAN_PAGE_TAG = 2'h2;
   localparam int CHAN_SHIFT = 5;
   localparam logic [4:0] CH_CONFIG_OFF = 5'h01;
   localparam logic [4:0] CH_TX_CFG_OFF = 5'h04;
   localparam logic [4:0] CH_RX_CFG_OFF = 5'h0a;
   localparam logic [4:0] CH_SYS_CFG_OFF = 5'h0b;
   localparam logic [4:0] CH_INT_MASK_OFF = 5'h11;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int LINE_MODE_BIT = 0;
   localparam int SOFT_RESET_BIT = 1;
   localparam int TERM_LSB = 0;
   localparam int SYS_FMT_LSB = 0;
   localparam int GPIO_DIR_LSB = 0;
   localparam int DBUS_EN_BIT = 4;

   // Reset values
   localparam logic LINE_MODE_T1J1 = 1'b0;
   localparam logic [2:0] TERM_RST = 3'h0;
   localparam logic [1:0] SYS_FMT_DUAL_NRZ = 2'h0;
   localparam logic [7:0] INT_MASK_RST = 8'hff;
   localparam logic [4:0] GPIO_RST = 5'h00;

   // Termination codes, shared by receive and transmit fields
   localparam logic [2:0] TERM_T1_100 = 3'h0;
   localparam logic [2:0] TERM_J1_110 = 3'h1;
   localparam logic [2:0] TERM_E1_120 = 3'h2;
   localparam logic [2:0] TERM_E1_75 = 3'h3;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int POR_TIME_US = 1000;
   localparam int SOFT_TIME_NS = 1000;
   localparam int POR_CYCLES = POR_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int SOFT_CYCLES = SOFT_TIME_NS / CLK_PERIOD_NS;
   localparam int CH_CNT_W = $clog2(SOFT_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_POR = 2'h0,
      ST_RUN = 2'h1,
      ST_SOFT = 2'h3
   } lrc_gstate_t;

endpackage : lrc_pkg

// ==== hdl/lrc_reset_ctrl.sv ====
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module lrc_reset_ctrl #(
   parameter int NCH = 16,
   parameter int POR_CYCLES = lrc_pkg::POR_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic mclk_ok_in,
   input wire logic hw_reset_n_in,
   input wire logic tx_output_enable_in,
   input wire logic rx_input_enable_in,
   input wire logic rx_impedance_pin_open_in,
   input wire logic [lrc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [lrc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [lrc_pkg::DATA_W-1:0] reg_rdata_out,
   output logic global_reset_out,
   output logic [NCH-1:0] chan_reset_out,
   output logic [NCH-1:0] tx_line_hiz_out,
   output logic [NCH-1:0] rx_line_hiz_out,
   output logic [NCH-1:0] channel_line_mode_out,
   output logic [2*NCH-1:0] sys_format_out,
   output logic [3*NCH-1:0] tx_term_out,
   output logic [3*NCH-1:0] rx_term_out,
   output logic [NCH-1:0] rx_int_term_en_out,
   output logic [8*NCH-1:0] int_mask_out,
   output logic [1:0] gpio_oe_n_out,
   output logic data_bus_oe_n_out
);

   ////////////////////////////////////////////////////////////////////////
   // State

   localparam int CNT_W = $clog2(POR_CYCLES + 1);
   localparam int CH_W = $clog2(NCH);
   localparam int CW = lrc_pkg::CH_CNT_W;

   typedef struct packed {
      lrc_pkg::lrc_gstate_t st;
      logic [CNT_W-1:0] cnt;
      logic glob;
      logic [NCH-1:0] mode;
      logic [NCH-1:0] busy;
      logic [NCH-1:0][CW-1:0] ch_cnt;
      logic [NCH-1:0][2:0] tterm;
      logic [NCH-1:0][2:0] rterm;
      logic [NCH-1:0][1:0] sfmt;
      logic [NCH-1:0][7:0] imask;
      logic [4:0] gpio;
      logic [lrc_pkg::DATA_W-1:0] rdata;
   } lrc_regs_t;

   localparam lrc_regs_t RESET_VAL = '{
      st: lrc_pkg::ST_POR,
      cnt: '0,
      glob: 1'b1,
      mode: {NCH{lrc_pkg::LINE_MODE_T1J1}},
      busy: '0,
      ch_cnt: '0,
      tterm: {NCH{lrc_pkg::TERM_RST}},
      rterm: {NCH{lrc_pkg::TERM_RST}},
      sfmt: {NCH{lrc_pkg::SYS_FMT_DUAL_NRZ}},
      imask: {NCH{lrc_pkg::INT_MASK_RST}},
      gpio: lrc_pkg::GPIO_RST,
      rdata: '0
   };

   lrc_regs_t q;
   lrc_regs_t d;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic chan_hit(input logic [lrc_pkg::ADDR_W-1:0] a);
      logic [CH_W-1:0] idx;
      idx = a[lrc_pkg::CHAN_SHIFT +: CH_W];
      chan_hit = (a[10:9] == lrc_pkg::CHAN_PAGE_TAG) && (32'(idx) < NCH);
   endfunction : chan_hit

   function automatic logic [CH_W-1:0] chan_idx(
      input logic [lrc_pkg::ADDR_W-1:0] a
   );
      chan_idx = a[lrc_pkg::CHAN_SHIFT +: CH_W];
   endfunction : chan_idx

   logic running;
   logic glb_reset_wr;
   logic [CH_W-1:0] wr_ch;
   logic [CH_W-1:0] rd_ch;
   logic [4:0] wr_off;
   logic [4:0] rd_off;
   logic [15:0] busy16;

   assign running = (q.st == lrc_pkg::ST_RUN);
   assign glb_reset_wr = reg_wr_in && running &&
                         (reg_addr_in == lrc_pkg::GLB_RESET_OFF);
   assign wr_ch = chan_idx(reg_addr_in);
   assign rd_ch = chan_idx(reg_addr_in);
   assign wr_off = reg_addr_in[4:0];
   assign rd_off = reg_addr_in[4:0];
   assign busy16 = 16'(q.busy);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      d.rdata = '0;

      // Global reset sequencer
      unique case (q.st)
         lrc_pkg::ST_POR: begin
            if (!mclk_ok_in) begin
               d.cnt = '0;
            end else if (q.cnt == CNT_W'(POR_CYCLES - 1)) begin
               d.st = lrc_pkg::ST_RUN;
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
            end
         end
         lrc_pkg::ST_RUN: begin
            if (!hw_reset_n_in || !mclk_ok_in || glb_reset_wr) begin
               d.st = lrc_pkg::ST_SOFT;
               d.cnt = '0;
            end
         end
         lrc_pkg::ST_SOFT: begin
            if (!hw_reset_n_in || !mclk_ok_in) begin
               d.cnt = '0;
            end else if (q.cnt == CNT_W'(lrc_pkg::SOFT_CYCLES - 1)) begin
               d.st = lrc_pkg::ST_RUN;
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
            end
         end
         default: begin
            d.st = lrc_pkg::ST_POR;
            d.cnt = '0;
         end
      endcase
      d.glob = (d.st != lrc_pkg::ST_RUN);

      // Per-channel reset timers
      for (int i = 0; i < NCH; i++) begin
         if (q.busy[i]) begin
            if (q.ch_cnt[i] == CW'(lrc_pkg::SOFT_CYCLES - 1)) begin
               d.busy[i] = 1'b0;
               d.ch_cnt[i] = '0;
            end else begin
               d.ch_cnt[i] = q.ch_cnt[i] + CW'(1);
            end
         end
      end

      // Register writes
      if (reg_wr_in && running) begin
         if (reg_addr_in == lrc_pkg::GLB_GPIO_OFF) begin
            d.gpio = reg_wdata_in[4:0];
         end else if (chan_hit(reg_addr_in) && !q.busy[wr_ch]) begin
            unique case (wr_off)
               lrc_pkg::CH_CONFIG_OFF: begin
                  d.mode[wr_ch] = reg_wdata_in[lrc_pkg::LINE_MODE_BIT];
                  if (reg_wdata_in[lrc_pkg::SOFT_RESET_BIT]) begin
                     d.busy[wr_ch] = 1'b1;
                     d.ch_cnt[wr_ch] = '0;
                  end
               end
               lrc_pkg::CH_TX_CFG_OFF: begin
                  d.tterm[wr_ch] = reg_wdata_in[lrc_pkg::TERM_LSB +: 3];
               end
               lrc_pkg::CH_RX_CFG_OFF: begin
                  d.rterm[wr_ch] = reg_wdata_in[lrc_pkg::TERM_LSB +: 3];
               end
               lrc_pkg::CH_SYS_CFG_OFF: begin
                  d.sfmt[wr_ch] = reg_wdata_in[lrc_pkg::SYS_FMT_LSB +: 2];
               end
               lrc_pkg::CH_INT_MASK_OFF: begin
                  d.imask[wr_ch] = reg_wdata_in;
               end
               default: begin
               end
            endcase
         end
      end

      // Channel reset holds that channel's registers, except its line mode, at defaults
      for (int i = 0; i < NCH; i++) begin
         if (d.busy[i]) begin
            d.tterm[i] = lrc_pkg::TERM_RST;
            d.rterm[i] = lrc_pkg::TERM_RST;
            d.sfmt[i] = lrc_pkg::SYS_FMT_DUAL_NRZ;
            d.imask[i] = lrc_pkg::INT_MASK_RST;
         end
      end

      // Global-class reset holds everything at defaults from its first cycle
      if (d.glob) begin
         d.mode = {NCH{lrc_pkg::LINE_MODE_T1J1}};
         d.busy = '0;
         d.ch_cnt = '0;
         d.tterm = {NCH{lrc_pkg::TERM_RST}};
         d.rterm = {NCH{lrc_pkg::TERM_RST}};
         d.sfmt = {NCH{lrc_pkg::SYS_FMT_DUAL_NRZ}};
         d.imask = {NCH{lrc_pkg::INT_MASK_RST}};
         d.gpio = lrc_pkg::GPIO_RST;
      end

      // Register reads, answered in the next cycle
      if (reg_rd_in) begin
         if (reg_addr_in == lrc_pkg::GLB_GPIO_OFF) begin
            d.rdata = {3'h0, q.gpio};
         end else if (reg_addr_in == lrc_pkg::GLB_BUSY_LO_OFF) begin
            d.rdata = busy16[7:0];
         end else if (reg_addr_in == lrc_pkg::GLB_BUSY_HI_OFF) begin
            d.rdata = busy16[15:8];
         end else if (chan_hit(reg_addr_in)) begin
            unique case (rd_off)
               lrc_pkg::CH_CONFIG_OFF: begin
                  d.rdata = {6'h0, q.busy[rd_ch], q.mode[rd_ch]};
               end
               lrc_pkg::CH_TX_CFG_OFF: begin
                  d.rdata = {5'h0, q.tterm[rd_ch]};
               end
               lrc_pkg::CH_RX_CFG_OFF: begin
                  d.rdata = {5'h0, q.rterm[rd_ch]};
               end
               lrc_pkg::CH_SYS_CFG_OFF: begin
                  d.rdata = {6'h0, q.sfmt[rd_ch]};
               end
               lrc_pkg::CH_INT_MASK_OFF: begin
                  d.rdata = q.imask[rd_ch];
               end
               default: begin
                  d.rdata = '0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= RESET_VAL;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata_out = q.rdata;
   assign global_reset_out = q.glob;
   assign chan_reset_out = q.busy | {NCH{q.glob}};

   // Enable pins act without any clock edge
   assign tx_line_hiz_out = ~{NCH{tx_output_enable_in}} | q.busy |
                            {NCH{q.glob}};
   assign rx_line_hiz_out = ~{NCH{rx_input_enable_in}} | q.busy |
                            {NCH{q.glob}};

   assign channel_line_mode_out = q.mode;
   assign sys_format_out = q.sfmt;
   assign tx_term_out = q.tterm;
   assign rx_term_out = q.rterm;
   assign rx_int_term_en_out = {NCH{~rx_impedance_pin_open_in}};
   assign int_mask_out = q.imask;
   assign gpio_oe_n_out = ~q.gpio[lrc_pkg::GPIO_DIR_LSB +: 2];
   assign data_bus_oe_n_out = ~q.gpio[lrc_pkg::DBUS_EN_BIT];

endmodule : lrc_reset_ctrl

`default_nettype wire

// ==== tb/lrc_reset_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrc_reset_ctrl_props #(
   parameter int NCH = 16,
   parameter int POR_CYCLES = 60
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic mclk_ok_in,
   input wire logic hw_reset_n_in,
   input wire logic tx_output_enable_in,
   input wire logic rx_input_enable_in,
   input wire logic rx_impedance_pin_open_in,
   input wire logic [lrc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [lrc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [lrc_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic global_reset_out,
   input wire logic [NCH-1:0] chan_reset_out,
   input wire logic [NCH-1:0] tx_line_hiz_out,
   input wire logic [NCH-1:0] rx_line_hiz_out,
   input wire logic [NCH-1:0] channel_line_mode_out,
   input wire logic [2*NCH-1:0] sys_format_out,
   input wire logic [3*NCH-1:0] tx_term_out,
   input wire logic [3*NCH-1:0] rx_term_out,
   input wire logic [NCH-1:0] rx_int_term_en_out,
   input wire logic [8*NCH-1:0] int_mask_out,
   input wire logic [1:0] gpio_oe_n_out,
   input wire logic data_bus_oe_n_out
);
   wire logic quiet = hw_reset_n_in && mclk_ok_in && !global_reset_out;
   wire logic glb_wr = reg_wr_in && quiet &&
      reg_addr_in == lrc_pkg::GLB_RESET_OFF;
   wire logic ch1_wr = reg_wr_in && quiet && reg_wdata_in[1] &&
      reg_addr_in == 11'h421 && chan_reset_out == '0;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////
   // Reset pulse: held, then released within 1 us
   sequence s_busy_run(sig);
      sig [*8] ##[1:43] !sig;
   endsequence
   a_glob_sw_len: assert property (glb_wr |=> s_busy_run(global_reset_out))
      else $error("global soft reset length wrong");
   a_chan_sw_len: assert property (ch1_wr |=> s_busy_run(chan_reset_out[1]))
      else $error("channel reset length wrong");
   a_chan_only_one: assert property (ch1_wr |=>
      chan_reset_out == (NCH'(1) << 1) && !global_reset_out)
      else $error("channel reset reached others");
   a_hiz_in_reset: assert property (
      (chan_reset_out & ~(tx_line_hiz_out & rx_line_hiz_out)) == '0)
      else $error("line pins driven during reset");
   a_glob_all_chan: assert property (global_reset_out |-> &chan_reset_out)
      else $error("global reset missed a channel");
   a_glob_defaults: assert property (global_reset_out |->
      channel_line_mode_out == '0 && &int_mask_out && sys_format_out == '0
      && gpio_oe_n_out == 2'b11 && data_bus_oe_n_out)
      else $error("defaults wrong in global reset");
   a_hw_hold: assert property (!hw_reset_n_in [*4] |-> global_reset_out)
      else $error("left reset with pin low");
   a_mclk_hold: assert property (!mclk_ok_in [*4] |-> global_reset_out)
      else $error("left reset without clock");
   a_tx_force: assert property (!tx_output_enable_in |-> &tx_line_hiz_out)
      else $error("tx not forced high impedance");
   a_rx_force: assert property (!rx_input_enable_in |-> &rx_line_hiz_out)
      else $error("rx not forced high impedance");
   a_rim_ignore: assert property (
      rx_int_term_en_out == {NCH{!rx_impedance_pin_open_in}})
      else $error("rx termination not dropped");
endmodule : lrc_reset_ctrl_props
bind lrc_reset_ctrl lrc_reset_ctrl_props #(.NCH(NCH),
   .POR_CYCLES(POR_CYCLES)) props_u (.*);
`default_nettype wire

// ==== tb/line_unit_reset_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_unit_reset_control_tb_top;
   logic clk_in = 0, rst_n_in = 0, mclk_ok_in = 0, hw_reset_n_in = 1;
   logic tx_output_enable_in = 1, rx_input_enable_in = 1;
   logic rx_impedance_pin_open_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic [10:0] reg_addr_in = '0;
   logic [7:0] reg_wdata_in = '0, reg_rdata_out, d;
   logic global_reset_out, data_bus_oe_n_out, rd_seen = 0;
   logic [1:0] gpio_oe_n_out;
   logic [15:0] chan_reset_out, tx_line_hiz_out, rx_line_hiz_out;
   logic [15:0] channel_line_mode_out, rx_int_term_en_out;
   logic [31:0] sys_format_out;
   logic [47:0] tx_term_out, rx_term_out;
   logic [127:0] int_mask_out;
   logic [7:0] exp_q[$];
   int bad_count = 0, compares = 0, n, ch;
   lrc_reset_ctrl #(.NCH(16), .POR_CYCLES(60)) dut_u (.*);
   always #10 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [10:0] a, input logic [7:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [10:0] a, input logic [7:0] e);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
   endtask : rd
   task wait_low(output int c);
      c = 0;
      while (global_reset_out !== 1'b0 && c < 2000) begin
         @(posedge clk_in);
         #1;
         c++;
      end
   endtask : wait_low
   function automatic logic [10:0] ca(int c, logic [4:0] off);
      return {2'h2, 4'(c), off};
   endfunction : ca
   task end_of_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////
   // Read answers checked in the cycle after the strobe
   always @(posedge clk_in) rd_seen <= reg_rd_in;
   always @(negedge clk_in) begin
      if (rd_seen)
         chk(reg_rdata_out, exp_q.pop_front());
   end
   initial begin
      #400000;
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(5494));
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (100) @(posedge clk_in);
      #1;
      chk(global_reset_out, 1);
      chk(channel_line_mode_out, 0);
      chk(int_mask_out, {16{8'hff}});
      chk(sys_format_out, 0);
      chk({gpio_oe_n_out, data_bus_oe_n_out}, 3'b111);
      chk(tx_line_hiz_out & rx_line_hiz_out, 16'hffff);
      @(posedge clk_in);
      mclk_ok_in <= 1'b1;
      wait_low(n);
      chk(n <= 62, 1);
      chk(tx_line_hiz_out | rx_line_hiz_out, 0);
      $display("test power-on done");
      ch = $urandom_range(15, 2);
      for (int k = 0; k < 4; k++) begin
         wr(ca(ch, lrc_pkg::CH_TX_CFG_OFF), 8'(k));
         wr(ca(ch, lrc_pkg::CH_RX_CFG_OFF), 8'(3 - k));
         rx_impedance_pin_open_in <= k[0];
         rd(ca(ch, lrc_pkg::CH_TX_CFG_OFF), 8'(k));
         rd(ca(ch, lrc_pkg::CH_RX_CFG_OFF), 8'(3 - k));
         chk(tx_term_out[3*ch+:3], 3'(k));
         chk(rx_term_out[3*ch+:3], 3'(3 - k));
         chk(rx_int_term_en_out, {16{~k[0]}});
      end
      wr(lrc_pkg::GLB_GPIO_OFF, 8'h13);
      rd(lrc_pkg::GLB_GPIO_OFF, 8'h13);
      chk({gpio_oe_n_out, data_bus_oe_n_out}, 3'b000);
      $display("test terminations done");
      d = 8'($urandom);
      wr(ca(1, lrc_pkg::CH_CONFIG_OFF), 8'h01);
      wr(ca(1, lrc_pkg::CH_INT_MASK_OFF), 8'h00);
      wr(ca(1, lrc_pkg::CH_SYS_CFG_OFF), 8'h01);
      wr(ca(1, lrc_pkg::CH_TX_CFG_OFF), 8'h03);
      wr(ca(ch, lrc_pkg::CH_INT_MASK_OFF), d);
      wr(ca(1, lrc_pkg::CH_CONFIG_OFF), 8'h03);
      #1;
      chk(chan_reset_out, 16'h0002);
      chk({global_reset_out, gpio_oe_n_out, data_bus_oe_n_out}, 0);
      chk(channel_line_mode_out[1], 1);
      chk(int_mask_out[15:8], 8'hff);
      chk(sys_format_out[3:2], 0);
      chk(tx_term_out[5:3], 0);
      chk(int_mask_out[8*ch+:8], d);
      chk(tx_line_hiz_out[1] & rx_line_hiz_out[1], 1);
      rd(lrc_pkg::GLB_BUSY_LO_OFF, 8'h02);
      n = 0;
      while (chan_reset_out[1] !== 1'b0 && n < 100) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk(n <= 50, 1);
      rd(ca(1, lrc_pkg::CH_CONFIG_OFF), 8'h01);
      rd(ca(1, lrc_pkg::CH_INT_MASK_OFF), 8'hff);
      $display("test channel reset done");
      wr(lrc_pkg::GLB_RESET_OFF, 8'($urandom));
      #1;
      chk({global_reset_out, chan_reset_out}, 17'h1ffff);
      wait_low(n);
      chk(n <= 50, 1);
      chk(channel_line_mode_out, 0);
      chk(int_mask_out, {16{8'hff}});
      chk({gpio_oe_n_out, data_bus_oe_n_out}, 3'b111);
      chk(tx_term_out, 0);
      rd(lrc_pkg::GLB_RESET_OFF, 8'h00);
      rd(11'h7ff, 8'h00);
      $display("test global reset done");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_in);
         if (i == 0)
            hw_reset_n_in <= 1'b0;
         else
            mclk_ok_in <= 1'b0;
         repeat (60) @(posedge clk_in);
         #1;
         chk(global_reset_out, 1);
         @(posedge clk_in);
         hw_reset_n_in <= 1'b1;
         mclk_ok_in <= 1'b1;
         wait_low(n);
         chk(n <= 55, 1);
      end
      $display("test pin and clock loss done");
      @(posedge clk_in);
      tx_output_enable_in <= 1'b0;
      rx_input_enable_in <= 1'b0;
      #1;
      chk({tx_line_hiz_out, rx_line_hiz_out}, 32'hffffffff);
      @(posedge clk_in);
      tx_output_enable_in <= 1'b1;
      rx_input_enable_in <= 1'b1;
      #1;
      chk(tx_line_hiz_out | rx_line_hiz_out, 0);
      $display("test enables done");
      end_of_test();
   end
endmodule : line_unit_reset_control_tb_top
`default_nettype wire
